// >>> hdl/can_obj_pkg.sv
// Constants, types and register map for the message object register window.
// Assumes an 8-bit special function register bus and four message objects.
package can_obj_pkg;
	localparam int NUM_OBJ = 4;
	typedef logic [1:0] obj_idx_t;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] dlc_t;
	typedef logic [10:0] ident_t;
	typedef logic [14:0] crc_t;
	// Object role, in field order 00, 01, 10, 11
	typedef enum logic [1:0] {CFG_DISABLE, CFG_TX, CFG_RX, CFG_RXBUF} obj_cfg_t;
	// Register offsets
	localparam byte_t ADDR_PAGE = 8'hb1;
	localparam byte_t ADDR_STATUS = 8'hb2;
	localparam byte_t ADDR_CTRL = 8'hb3;
	localparam byte_t ADDR_IDT1 = 8'hbc;
	localparam byte_t ADDR_IDT2 = 8'hbd;
	localparam byte_t ADDR_IDT3 = 8'hbe;
	localparam byte_t ADDR_IDT4 = 8'hbf;
	// Page register fields
	localparam int PAGE_NUM_LSB = 4;
	localparam byte_t PAGE_WR_MASK = 8'h3f;
	localparam byte_t PAGE_RESET = 8'h00;
	// Control and length register fields
	localparam int CTRL_CFG_LSB = 6;
	localparam int CTRL_REPLY_VALID_BIT = 5;
	localparam int CTRL_IDE_BIT = 4;
	localparam dlc_t DLC_MAX = 4'h8;
	// Status register fields
	localparam int ST_LENGTH_WARNING = 7;
	localparam int ST_TRANSMIT_DONE = 6;
	localparam int ST_RECEIVE_DONE = 5;
	localparam int ST_BIT_ERROR_FLAG = 4;
	localparam int ST_STUFF_ERROR_FLAG = 3;
	localparam int ST_CRC_ERROR_FLAG = 2;
	localparam int ST_FORM_ERROR_FLAG = 1;
	localparam int ST_ACK_ERROR_FLAG = 0;
	// Identifier tag fields
	localparam int IDT2_LSB = 5;
	localparam int IDT4_RTR_BIT = 2;
	localparam int IDT4_RB0_BIT = 0;
	// Object registers have no documented reset; cleared for determinism
	localparam byte_t OBJ_RESET = 8'h00;
	// Bus protocol figures
	localparam logic [2:0] STUFF_LIMIT = 3'h5;
	localparam crc_t CRC_POLY = 15'h4599;
	localparam crc_t CRC_INIT = 15'h0000;
endpackage : can_obj_pkg

// >>> hdl/can_message_object_regs.sv
// Message object register window: page select, control, status, identifier tags.
// Assumes a protocol engine alongside that supplies bit ticks, field phases and frame
// events, all synchronous to clk.
// What this block does
// RULE_01 - Configuration field sets object role
// RULE_02 - Software rewrites configuration to enable object
// RULE_03 - Auto reply sent only when reply valid
// RULE_04 - Extension bit selects 11 or 29 bit
// RULE_05 - Length code counts bytes, zero to eight
// RULE_06 - Received frame overwrites stored length code
// RULE_07 - Differing received length sets warning flag
// RULE_08 - Length replaced even when warning raised
// RULE_09 - Transmit done flag on successful send
// RULE_10 - Lowest index transmitter goes first
// RULE_11 - Receive done flag on successful reception
// RULE_12 - Lowest index hit object updated first
// RULE_13 - Bit error when monitored differs from driven
// RULE_14 - No bit error in arbitration, ack exceptions; code exempts the ack slot only while err_frame_tx is set
// RULE_15 - Stuff error after five equal bits
// RULE_16 - Receiver CRC mismatch sets CRC error
// RULE_17 - Form error on delimiter or frame end
// RULE_18 - Ack error when no dominant ack
// RULE_19 - First tag byte holds identifier ten..three
// RULE_20 - Second tag byte holds identifier two..zero
// RULE_21 - Third tag byte entirely reserved
// RULE_22 - Fourth tag byte: remote and reserved tags
// RULE_23 - Page object number selects accessed object
// RULE_24 - Flags stay set until software clears
// RULE_25 - Only enabled flag sources raise request
`timescale 1ns/1ns
`default_nettype none
module can_message_object_regs
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Special function register access
	input wire can_obj_pkg::byte_t sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire can_obj_pkg::byte_t sfr_wdata,
	output can_obj_pkg::byte_t sfr_rdata,
	// Transmit selection towards the protocol engine
	input wire logic tx_ready,
	output logic tx_req,
	output can_obj_pkg::obj_idx_t tx_obj,
	output can_obj_pkg::ident_t tx_ident,
	output logic tx_ide,
	output can_obj_pkg::dlc_t tx_dlc,
	output logic tx_remote_tag,
	input wire logic tx_done,
	// Reception results
	input wire logic [3:0] rx_hit,
	input wire logic rx_remote,
	input wire can_obj_pkg::dlc_t rx_dlc,
	// Bit level view of the current frame
	input wire can_obj_pkg::obj_idx_t frame_obj,
	input wire logic bit_tick,
	input wire logic bus_level,
	input wire logic drive_level,
	input wire logic tx_active,
	input wire logic in_arbitration,
	input wire logic err_frame_tx,
	input wire logic stuff_region,
	input wire logic crc_region,
	input wire logic crc_field,
	input wire logic crc_field_end,
	input wire logic fixed_form_bit,
	input wire logic ack_slot,
	// Object enables and flag requests
	input wire can_obj_pkg::byte_t int_src_enable,
	output logic [3:0] object_enable,
	output logic [3:0] obj_int
);
	import can_obj_pkg::*;

	// Lowest set bit of a four-bit vector
	function automatic obj_idx_t lowest(input logic [3:0] v);
		obj_idx_t r;
		r = 2'h0;
		for (int k = NUM_OBJ - 1; k >= 0; k--)
		begin
			if (v[k])
				r = obj_idx_t'(k);
		end
		return r;
	endfunction : lowest

	////////////////////////////////////////////////////////////////////////////////
	// Page register and per-object storage
	byte_t page_r, page_nxt;
	obj_idx_t page_obj;
	byte_t ctrl_r [NUM_OBJ];
	byte_t stat_r [NUM_OBJ];
	byte_t idt1_r [NUM_OBJ];
	logic [2:0] idt2_r [NUM_OBJ];
	logic [NUM_OBJ-1:0] rtr_r, rb0_r, en_r, rpend_r;
	logic [3:0] tx_cand, rx_ok;
	obj_idx_t rx_sel;
	logic [4:0] err_vec;

	// Object number picks the register set
	assign page_obj = page_r[PAGE_NUM_LSB +: 2]; // RULE_23

	// Page register next value
	always_comb
	begin
		page_nxt = page_r;
		if (sfr_wr && sfr_addr == ADDR_PAGE)
			page_nxt = sfr_wdata & PAGE_WR_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			page_r <= PAGE_RESET;
		else
			page_r <= page_nxt;
	end

	// Only the lowest enabled hit object takes the frame
	assign rx_ok = rx_hit & en_r;
	assign rx_sel = lowest(rx_ok); // RULE_12

	////////////////////////////////////////////////////////////////////////////////
	// Per-object register sets
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OBJ; gi++)
		begin : g_obj
			byte_t ctrl_nxt, stat_nxt, idt1_nxt, set_bits;
			logic [2:0] idt2_nxt;
			logic rtr_nxt, rb0_nxt, en_nxt, rpend_nxt, sel, rx_take, tx_fin;

			assign sel = (page_obj == obj_idx_t'(gi));
			assign rx_take = |rx_ok && rx_sel == obj_idx_t'(gi);
			assign tx_fin = tx_done && frame_obj == obj_idx_t'(gi);

			// Software writes first, hardware events override
			always_comb
			begin
				ctrl_nxt = ctrl_r[gi];
				stat_nxt = stat_r[gi];
				idt1_nxt = idt1_r[gi];
				idt2_nxt = idt2_r[gi];
				rtr_nxt = rtr_r[gi];
				rb0_nxt = rb0_r[gi];
				en_nxt = en_r[gi];
				rpend_nxt = rpend_r[gi];
				set_bits = 8'h00;
				if (sfr_wr && sel)
				begin
					unique case (sfr_addr)
						ADDR_CTRL:
						begin
							ctrl_nxt = sfr_wdata; // RULE_01 RULE_04 RULE_05
							en_nxt = sfr_wdata[CTRL_CFG_LSB +: 2] != CFG_DISABLE; // RULE_02
						end
						ADDR_STATUS: stat_nxt = stat_r[gi] & sfr_wdata; // RULE_24
						ADDR_IDT1: idt1_nxt = sfr_wdata; // RULE_19
						ADDR_IDT2: idt2_nxt = sfr_wdata[IDT2_LSB +: 3]; // RULE_20
						ADDR_IDT4:
						begin
							rtr_nxt = sfr_wdata[IDT4_RTR_BIT]; // RULE_22
							rb0_nxt = sfr_wdata[IDT4_RB0_BIT];
						end
						default: ; // Reserved third tag byte ignores writes
					endcase
				end
				if (rx_take)
				begin
					ctrl_nxt[3:0] = rx_dlc; // RULE_06 RULE_08
					set_bits[ST_RECEIVE_DONE] = 1'b1; // RULE_11
					set_bits[ST_LENGTH_WARNING] = rx_dlc != ctrl_r[gi][3:0]; // RULE_07
					if (rx_remote)
						rpend_nxt = 1'b1;
				end
				if (tx_fin)
				begin
					set_bits[ST_TRANSMIT_DONE] = 1'b1; // RULE_09
					en_nxt = 1'b0;
					rpend_nxt = 1'b0;
				end
				if (frame_obj == obj_idx_t'(gi))
					set_bits[4:0] = set_bits[4:0] | err_vec;
				// Set beats a same-cycle clear
				stat_nxt = stat_nxt | set_bits; // RULE_24
			end

			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					ctrl_r[gi] <= OBJ_RESET;
					stat_r[gi] <= OBJ_RESET;
					idt1_r[gi] <= OBJ_RESET;
					idt2_r[gi] <= 3'h0;
					rtr_r[gi] <= 1'b0;
					rb0_r[gi] <= 1'b0;
					en_r[gi] <= 1'b0;
					rpend_r[gi] <= 1'b0;
				end
				else
				begin
					ctrl_r[gi] <= ctrl_nxt;
					stat_r[gi] <= stat_nxt;
					idt1_r[gi] <= idt1_nxt;
					idt2_r[gi] <= idt2_nxt;
					rtr_r[gi] <= rtr_nxt;
					rb0_r[gi] <= rb0_nxt;
					en_r[gi] <= en_nxt;
					rpend_r[gi] <= rpend_nxt;
				end
			end

			// Transmitters, or a pending auto reply once marked valid
			assign tx_cand[gi] = en_r[gi] && (ctrl_r[gi][CTRL_CFG_LSB +: 2] == CFG_TX
				|| (rpend_r[gi] && ctrl_r[gi][CTRL_REPLY_VALID_BIT])); // RULE_03
			// Masked flags stay visible but do not interrupt
			assign obj_int[gi] = |(stat_r[gi] & int_src_enable); // RULE_25
		end
	endgenerate

	assign object_enable = en_r;

	////////////////////////////////////////////////////////////////////////////////
	// Bit level error detection
	logic [2:0] run_r, run_nxt;
	logic last_r, last_nxt;
	crc_t crc_r, crc_nxt, rcrc_r, rcrc_nxt;
	logic fb;

	// Stuff run length and CRC shifters
	always_comb
	begin
		run_nxt = run_r;
		last_nxt = last_r;
		crc_nxt = crc_r;
		rcrc_nxt = rcrc_r;
		fb = bus_level ^ crc_r[14];
		if (!stuff_region)
			run_nxt = 3'h0;
		else if (bit_tick)
		begin
			last_nxt = bus_level;
			if (run_r != 3'h0 && bus_level == last_r && run_r != STUFF_LIMIT)
				run_nxt = run_r + 3'h1;
			else if (run_r == 3'h0 || bus_level != last_r)
				run_nxt = 3'h1;
		end
		if (!crc_region && !crc_field && !crc_field_end)
		begin
			crc_nxt = CRC_INIT;
			rcrc_nxt = CRC_INIT;
		end
		else if (bit_tick && crc_region)
			crc_nxt = {crc_r[13:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT); // RULE_16
		else if (bit_tick && crc_field)
			rcrc_nxt = {rcrc_r[13:0], bus_level};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			run_r <= 3'h0;
			last_r <= 1'b0;
			crc_r <= CRC_INIT;
			rcrc_r <= CRC_INIT;
		end
		else
		begin
			run_r <= run_nxt;
			last_r <= last_nxt;
			crc_r <= crc_nxt;
			rcrc_r <= rcrc_nxt;
		end
	end

	// Error pulses, ordered as status bits four down to zero
	always_comb
	begin
		err_vec = 5'h00;
		err_vec[ST_BIT_ERROR_FLAG] = bit_tick && tx_active && bus_level != drive_level // RULE_13
			&& !(in_arbitration && drive_level && !bus_level) // RULE_14
			&& !(ack_slot && err_frame_tx && !bus_level);
		err_vec[ST_STUFF_ERROR_FLAG] = bit_tick && stuff_region && run_r == STUFF_LIMIT
			&& bus_level == last_r; // RULE_15
		err_vec[ST_CRC_ERROR_FLAG] = crc_field_end && !tx_active && rcrc_r != crc_r; // RULE_16
		err_vec[ST_FORM_ERROR_FLAG] = bit_tick && fixed_form_bit && !bus_level; // RULE_17
		err_vec[ST_ACK_ERROR_FLAG] = bit_tick && ack_slot && tx_active && bus_level; // RULE_18
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit selection and register read-back
	byte_t rdata_r, rdata_nxt;
	logic txreq_r, txreq_nxt, ide_r, ide_nxt, rtag_r, rtag_nxt;
	obj_idx_t txobj_r, txobj_nxt;
	ident_t ident_r, ident_nxt;
	dlc_t dlc_r, dlc_nxt;

	always_comb
	begin
		txreq_nxt = tx_ready && |tx_cand;
		txobj_nxt = lowest(tx_cand); // RULE_10
		ident_nxt = {idt1_r[txobj_nxt], idt2_r[txobj_nxt]}; // RULE_19 RULE_20
		ide_nxt = ctrl_r[txobj_nxt][CTRL_IDE_BIT]; // RULE_04
		dlc_nxt = ctrl_r[txobj_nxt][3:0] > DLC_MAX ? DLC_MAX : ctrl_r[txobj_nxt][3:0]; // RULE_05
		rtag_nxt = rtr_r[txobj_nxt];
		rdata_nxt = rdata_r;
		if (sfr_rd)
		begin
			unique case (sfr_addr)
				ADDR_PAGE: rdata_nxt = page_r;
				ADDR_STATUS: rdata_nxt = stat_r[page_obj];
				ADDR_CTRL: rdata_nxt = ctrl_r[page_obj];
				ADDR_IDT1: rdata_nxt = idt1_r[page_obj];
				ADDR_IDT2: rdata_nxt = {idt2_r[page_obj], 5'h00};
				ADDR_IDT4: rdata_nxt = {5'h00, rtr_r[page_obj], 1'b0, rb0_r[page_obj]}; // RULE_22
				default: rdata_nxt = 8'h00; // RULE_21
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_r <= 8'h00;
			txreq_r <= 1'b0;
			txobj_r <= 2'h0;
			ident_r <= 11'h000;
			ide_r <= 1'b0;
			dlc_r <= 4'h0;
			rtag_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			txreq_r <= txreq_nxt;
			txobj_r <= txobj_nxt;
			ident_r <= ident_nxt;
			ide_r <= ide_nxt;
			dlc_r <= dlc_nxt;
			rtag_r <= rtag_nxt;
		end
	end

	assign sfr_rdata = rdata_r;
	assign tx_req = txreq_r;
	assign tx_obj = txobj_r;
	assign tx_ident = ident_r;
	assign tx_ide = ide_r;
	assign tx_dlc = dlc_r;
	assign tx_remote_tag = rtag_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rx_into0;
		rx_ok[0] ##1 1'b1;
	endsequence

	property p_cfg_enable;
		sfr_wr && sfr_addr == ADDR_CTRL && page_obj == 2'h1 && sfr_wdata[7:6] != 2'h0
			&& !(tx_done && frame_obj == 2'h1) |=> en_r[1];
	endproperty
	a_cfg_enable: assert property (p_cfg_enable) else $error("config write did not enable"); // RULE_02

	property p_tx_lowest;
		tx_req |-> ($past(tx_cand) & ((4'h1 << tx_obj) - 4'h1)) == 4'h0;
	endproperty
	a_tx_lowest: assert property (p_tx_lowest) else $error("lower object skipped"); // RULE_10

	property p_reply_gate;
		tx_req |-> $past(ctrl_r[txobj_nxt][7:6]) == 2'h1
			|| $past(ctrl_r[txobj_nxt][CTRL_REPLY_VALID_BIT]);
	endproperty
	a_reply_gate: assert property (p_reply_gate) else $error("reply sent while not valid"); // RULE_03

	property p_dlc_update;
		dlc_t d;
		(rx_ok[0], d = rx_dlc) |=> ctrl_r[0][3:0] == d;
	endproperty
	a_dlc_update: assert property (p_dlc_update) else $error("length code not updated"); // RULE_06

	property p_length_warning;
		rx_ok[0] && rx_dlc != ctrl_r[0][3:0] |=> stat_r[0][ST_LENGTH_WARNING] && stat_r[0][ST_RECEIVE_DONE];
	endproperty
	a_length_warning: assert property (p_length_warning) else $error("length warning missing"); // RULE_07

	property p_rx_buffer;
		s_rx_into0 |-> !$past(rx_ok[2]) || ctrl_r[2][3:0] == $past(ctrl_r[2][3:0]);
	endproperty
	a_rx_buffer: assert property (p_rx_buffer) else $error("higher object updated first"); // RULE_12

	property p_sticky;
		stat_r[1][ST_TRANSMIT_DONE] && !(sfr_wr && sfr_addr == ADDR_STATUS && page_obj == 2'h1)
			|=> stat_r[1][ST_TRANSMIT_DONE];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared by hardware"); // RULE_24

	property p_stuff;
		bit_tick && stuff_region && run_r == 3'h5 && bus_level == last_r && frame_obj == 2'h0
			|=> stat_r[0][ST_STUFF_ERROR_FLAG];
	endproperty
	a_stuff: assert property (p_stuff) else $error("stuff error missed"); // RULE_15

	property p_arb_exempt;
		in_arbitration && drive_level && !bus_level |-> !err_vec[ST_BIT_ERROR_FLAG];
	endproperty
	a_arb_exempt: assert property (p_arb_exempt) else $error("bit error in arbitration"); // RULE_14

	property p_ack;
		bit_tick && ack_slot && tx_active && bus_level && frame_obj == 2'h0
			|=> stat_r[0][ST_ACK_ERROR_FLAG] [*2];
	endproperty
	a_ack: assert property (p_ack) else $error("ack error missed"); // RULE_18

	property p_masked;
		(stat_r[0] & int_src_enable) == 8'h00 |-> !obj_int[0];
	endproperty
	a_masked: assert property (p_masked) else $error("masked flag raised request"); // RULE_25
endmodule : can_message_object_regs
`default_nettype wire

// >>> testbench/can_far_node_model.sv
// Far side model: protocol engine and other bus nodes, as events and bit samples.
// Assumes the bench calls its tasks; every change lands at the falling edge of clk.
`timescale 1ns/1ns
`default_nettype none
module can_far_node_model
(
	// Clock
	input wire logic clk,
	// Frame events
	output logic tx_ready,
	output logic tx_done,
	output logic [3:0] rx_hit,
	output logic rx_remote,
	output can_obj_pkg::dlc_t rx_dlc,
	output can_obj_pkg::obj_idx_t frame_obj,
	// Bit view; phase is tx, arbitration, error frame, stuff, fixed form, ack slot
	output logic bit_tick,
	output logic bus_level,
	output logic drive_level,
	output logic [5:0] phase,
	// CRC view: region, received field, field end
	output logic [2:0] crc_ph
);
	import can_obj_pkg::*;
	// Idle bus is recessive with no events
	initial
	begin
		{tx_ready, tx_done, rx_hit, rx_remote, bit_tick, phase, crc_ph} = '0;
		{rx_dlc, frame_obj} = '0;
		{bus_level, drive_level} = 2'b11;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Engine readiness level
	task ready(input logic v);
		@(negedge clk) tx_ready = v;
	endtask : ready
	// One finished transmission
	task done(input obj_idx_t o);
		@(negedge clk);
		frame_obj = o;
		tx_done = 1'b1;
		@(negedge clk);
		tx_done = 1'b0;
	endtask : done
	// Received frame; length stays within zero to eight
	task hit(input logic [3:0] m, input logic r, input dlc_t d);
		@(negedge clk);
		rx_hit = m;
		rx_remote = r;
		rx_dlc = (d > 4'h8) ? 4'h8 : d;
		@(negedge clk);
		rx_hit = 4'h0;
		rx_remote = ~r;
		rx_dlc = ~rx_dlc;
	endtask : hit
	// One sampled bit; phase levels hold until the next bit
	task bit_cyc(input obj_idx_t o, input logic [5:0] ph, input logic b, input logic d);
		@(negedge clk);
		frame_obj = o;
		phase = ph;
		bus_level = b;
		drive_level = d;
		bit_tick = 1'b1;
		@(negedge clk);
		bit_tick = 1'b0;
	endtask : bit_cyc
	// Received frame: one region bit of one, the given CRC field, then the field end
	task crc_frame(input crc_t r);
		@(negedge clk);
		{frame_obj, phase, crc_ph} = {2'h0, 6'h00, 3'b100};
		{bus_level, bit_tick} = 2'b11;
		@(negedge clk);
		crc_ph = 3'b010;
		for (int i = 14; i >= 0; i--)
		begin
			bus_level = r[i];
			@(negedge clk);
		end
		{crc_ph, bit_tick} = 4'b0010;
		@(negedge clk);
		crc_ph = 3'b000;
	endtask : crc_frame
endmodule : can_far_node_model
`default_nettype wire

// >>> testbench/test_can_message_object_regs.sv
// Self-checking bench for the message object register window.
// Assumes the far side model drives all engine inputs; the CRC path is driven by its crc_frame task.
`timescale 1ns/1ns
`default_nettype none
module test_can_message_object_regs;
	import can_obj_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	byte_t sfr_addr, sfr_wdata, sfr_rdata, int_src_enable;
	logic sfr_wr, sfr_rd;
	logic [2:0] crc_ph;
	logic tx_ready, tx_done, rx_remote, bit_tick, bus_level, drive_level;
	logic tx_req, tx_ide, tx_remote_tag;
	logic [3:0] rx_hit, object_enable, obj_int;
	logic [5:0] phase;
	dlc_t rx_dlc, tx_dlc;
	obj_idx_t frame_obj, tx_obj;
	ident_t tx_ident;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	// Error cases: phase, bus, driven, expected status
	logic [15:0] ecase [6] = '{16'h8110, 16'hc100, 16'ha500, 16'h0802, 16'h8701, 16'h0b00};
	// Clock
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	can_far_node_model can_far_node_model_i
	(
		.clk(clk), .tx_ready(tx_ready), .tx_done(tx_done), .rx_hit(rx_hit),
		.rx_remote(rx_remote), .rx_dlc(rx_dlc), .frame_obj(frame_obj), .bit_tick(bit_tick),
		.bus_level(bus_level), .drive_level(drive_level), .phase(phase), .crc_ph(crc_ph)
	);
	can_message_object_regs can_message_object_regs_i
	(
		.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_ready(tx_ready), .tx_req(tx_req),
		.tx_obj(tx_obj), .tx_ident(tx_ident), .tx_ide(tx_ide), .tx_dlc(tx_dlc),
		.tx_remote_tag(tx_remote_tag), .tx_done(tx_done), .rx_hit(rx_hit),
		.rx_remote(rx_remote), .rx_dlc(rx_dlc), .frame_obj(frame_obj), .bit_tick(bit_tick),
		.bus_level(bus_level), .drive_level(drive_level), .tx_active(phase[5]),
		.in_arbitration(phase[4]), .err_frame_tx(phase[3]), .stuff_region(phase[2]),
		.crc_region(crc_ph[2]), .crc_field(crc_ph[1]), .crc_field_end(crc_ph[0]),
		.fixed_form_bit(phase[1]), .ack_slot(phase[0]), .int_src_enable(int_src_enable),
		.object_enable(object_enable), .obj_int(obj_int)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Register write, one strobe cycle
	task wr(input byte_t a, input byte_t d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
		sfr_wdata = ~d;
	endtask : wr
	// Register read and compare
	task rd(input byte_t a, input byte_t e);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk(sfr_rdata, e);
	endtask : rd
	// Object page select
	task pg(input obj_idx_t o);
		wr(ADDR_PAGE, {2'b00, o, 4'h0});
	endtask : pg
	// Closing report
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{sfr_addr, sfr_wdata, int_src_enable, sfr_wr, sfr_rd} = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		// Reset state, reserved page bits, tag byte layout
		rd(ADDR_STATUS, 8'h00);
		chk(object_enable, 4'h0);
		wr(ADDR_PAGE, 8'hff);
		rd(ADDR_PAGE, 8'h3f);
		pg(2'd3);
		wr(ADDR_IDT1, 8'ha5);
		wr(ADDR_IDT2, 8'hff);
		wr(ADDR_IDT3, 8'hff);
		wr(ADDR_IDT4, 8'hff);
		wr(ADDR_CTRL, 8'h57);
		rd(ADDR_IDT1, 8'ha5);
		rd(ADDR_IDT2, 8'he0);
		rd(ADDR_IDT3, 8'h00);
		rd(ADDR_IDT4, 8'h05);
		rd(ADDR_CTRL, 8'h57);
		pg(2'd1);
		rd(ADDR_IDT1, 8'h00);
		// Every role code on object one
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_CTRL, {c[1:0], 6'h02});
			@(negedge clk);
			chk(object_enable[1], c != 0);
		end
		// Two transmitters: lower index first
		wr(ADDR_CTRL, 8'h4f);
		can_far_node_model_i.ready(1'b1);
		repeat (2) @(negedge clk);
		chk({tx_req, tx_obj, tx_dlc}, {1'b1, 2'd1, 4'h8});
		can_far_node_model_i.done(2'd1);
		@(negedge clk);
		chk(object_enable, 4'b1000);
		chk({tx_req, tx_obj, tx_ide, tx_remote_tag, tx_dlc}, {1'b1, 2'd3, 2'b11, 4'h7});
		chk(tx_ident, 11'h52f);
		rd(ADDR_STATUS, 8'h40);
		can_far_node_model_i.done(2'd3);
		can_far_node_model_i.ready(1'b0);
		// Two receivers hit at once
		pg(2'd2);
		wr(ADDR_CTRL, 8'h83);
		pg(2'd0);
		wr(ADDR_CTRL, 8'h83);
		can_far_node_model_i.hit(4'b0101, 1'b0, 4'h6);
		rd(ADDR_CTRL, 8'h86);
		rd(ADDR_STATUS, 8'ha0);
		pg(2'd2);
		rd(ADDR_STATUS, 8'h00);
		// Remote frame answered only once reply-valid is set
		can_far_node_model_i.hit(4'b0100, 1'b1, 4'h3);
		rd(ADDR_STATUS, 8'h20);
		can_far_node_model_i.ready(1'b1);
		repeat (2) @(negedge clk);
		chk(tx_req, 1'b0);
		wr(ADDR_CTRL, 8'ha3);
		repeat (2) @(negedge clk);
		chk({tx_req, tx_obj}, {1'b1, 2'd2});
		can_far_node_model_i.done(2'd2);
		can_far_node_model_i.ready(1'b0);
		// Error events on object zero, status cleared before each
		pg(2'd0);
		for (int i = 0; i < 6; i++)
		begin
			wr(ADDR_STATUS, 8'h00);
			can_far_node_model_i.bit_cyc(2'd0, ecase[i][15:10], ecase[i][9], ecase[i][8]);
			rd(ADDR_STATUS, ecase[i][7:0]);
		end
		// Five equal bits pass, the sixth is an error
		wr(ADDR_STATUS, 8'h00);
		repeat (5) can_far_node_model_i.bit_cyc(2'd0, 6'h04, 1'b0, 1'b0);
		rd(ADDR_STATUS, 8'h00);
		can_far_node_model_i.bit_cyc(2'd0, 6'h04, 1'b0, 1'b0);
		rd(ADDR_STATUS, 8'h08);
		// Masked sources stay visible but quiet
		@(negedge clk) int_src_enable = 8'h08;
		@(negedge clk);
		chk(obj_int, 4'b0001);
		int_src_enable = 8'hf7;
		@(negedge clk);
		chk(obj_int, 4'b1110);
		rd(ADDR_STATUS, 8'h08);
		// Receiver CRC: a matching field is quiet, one flipped bit is an error
		wr(ADDR_STATUS, 8'h00);
		can_far_node_model_i.crc_frame(CRC_POLY);
		rd(ADDR_STATUS, 8'h00);
		can_far_node_model_i.crc_frame(CRC_POLY ^ 15'h0001);
		rd(ADDR_STATUS, 8'h04);
		end_of_test();
	end
endmodule : test_can_message_object_regs
`default_nettype wire
